//--- fpol_pkg.sv
// Package: constants for the sector protection and security register logic
package fpol_pkg;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_READ_PROT   = 8'h3c;
   localparam logic [7:0] OP_PROG_SECUR  = 8'h9b;
   localparam logic [7:0] OP_WRITE_EN    = 8'h11;
   localparam logic [7:0] OP_WRITE_STAT  = 8'h12;
   localparam logic [7:0] OP_PROT_SECT   = 8'h13;
   localparam logic [7:0] OP_UNPROT_SECT = 8'h14;
   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam logic [2:0] BYTE_OPCODE    = 3'h0;
   localparam logic [2:0] BYTE_ADDR_HI   = 3'h1;
   localparam logic [2:0] BYTE_ADDR_MID  = 3'h2;
   localparam logic [2:0] BYTE_ADDR_LO   = 3'h3;
   localparam logic [2:0] BYTES_ADDRESSED = 3'h4;
   localparam logic [2:0] BYTES_WITH_DATA = 3'h5;
   // ----------------------------------------------------------------
   // Security area
   // ----------------------------------------------------------------
   localparam int         SECUR_BYTES    = 128;
   localparam int         USER_BYTES     = 64;
   localparam int         USER_AW        = 6;
   // ----------------------------------------------------------------
   // Status byte fields and codes
   // ----------------------------------------------------------------
   localparam int         ST_LOCK_POS    = 7;
   localparam int         ST_WP_POS      = 4;
   localparam int         ST_SWP_POS     = 2;
   localparam int         ST_WEL_POS     = 1;
   localparam int         ST_BUSY_POS    = 0;
   localparam logic [1:0] SWP_NONE       = 2'h0;
   localparam logic [1:0] SWP_SOME       = 2'h1;
   localparam logic [1:0] SWP_ALL        = 2'h3;
   localparam logic [3:0] GLOBAL_PROT    = 4'hf;
   localparam logic [3:0] GLOBAL_UNPROT  = 4'h0;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic       FLAG_RST       = 1'b1;
   localparam logic       LOCK_RST       = 1'b0;
   // ----------------------------------------------------------------
   // Timing and FIFO size
   // ----------------------------------------------------------------
   localparam int         CLK_FREQ_MHZ   = 10;
   localparam int         SEC_PROG_TIME_US = 1000;
   localparam int         FIFO_DEPTH     = 8;
endpackage

//--- fpol_protect_otp.sv
// Sector protection, locking and security-area programming with its data FIFO
`timescale 1ns/100ps

// --------------------------------------------------------------------
// Data FIFO
// --------------------------------------------------------------------
module fpol_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Filling side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Draining side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } fpol_fifo_t;
   fpol_fifo_t r;
   fpol_fifo_t r_nxt;
   logic       do_push;
   logic       do_pop;

   assign in_ready  = r.cnt != (AW+1)'(D);
   assign out_valid = r.cnt != '0;
   assign out_data  = r.mem[r.rp];
   assign do_push   = in_valid && in_ready;
   assign do_pop    = out_valid && out_ready;

   always_comb begin
      r_nxt = r;
      if (do_push) begin
         r_nxt.mem[r.wp] = in_data;
         r_nxt.wp        = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
      end
      if (do_pop) begin
         r_nxt.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
      end
      r_nxt.cnt = r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end
endmodule

// Summary of operation
// - Sector flag query: opcode 3Ch then three address bytes inside the sector.
// - After the last address byte, serial out repeats FFh if protected, else 00h.
// - Chip select release ends the flag read and floats serial out.
// - Flag read data carries only the sector flag, never write-protect.
// - Hardware lock only while write-protect asserted and lock bit set.
// - Hardware lock freezes flags and lock bit, drops protect, unprotect, status write.
// - A status write clearing the lock bit applies no global change.
// - With write-protect held asserted, a set lock bit clears only by reset.
// - Unlocked status write may set lock bit and apply global change from bits 5:2.
// - Software lock ignores sector and global changes, but lock bit may clear.
// - Sector is protected when its flag is one, regardless of write-protect.
// - Security area 128 bytes; 0-63 user one-time, 64-127 fixed forever.
// - Security program needs write enable, then 9Bh, address, buffered data.
// - Security program start location uses only address bits 5:0.
// - Data beyond user location 63 wraps to location 0.
// - Over 64 data bytes: only the last 64 stay buffered.
// - Release starts self-timed write; unsent user bytes stay FFh.
// - Full address, one whole data byte, byte-aligned release, else abort.
// - Aborted security program clears the write-enable latch.
// - User area programmed once as a unit; later programs refused.
// - Busy during security write; write enable cleared before completion.
// - Security program overwrites the shared page buffer.
// - Status write stores only bit 7; bits 5:2 only request globals.
// - Summary field reads 00 none, 01 some, 11 all flags set.
// - Status bit 0 is one while a self-timed operation runs.
module fpol_protect_otp #(
   parameter int NUM_SECTORS      = 4,
   parameter int SECTOR_LSB       = 16,
   parameter int SEC_PROG_TIME_US = fpol_pkg::SEC_PROG_TIME_US
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   // Serial link pins
   input  wire logic                   cs_n,
   input  wire logic                   sck,
   input  wire logic                   si,
   output logic                        so,
   output logic                        so_oe_n,
   // Write-protect pin
   input  wire logic                   wp_n,
   // Status and protection view
   output logic [7:0]                  status_byte,
   output logic [NUM_SECTORS-1:0]      sector_flags,
   output logic                        user_area_used,
   // Nonvolatile security-area write port
   output logic                        nvm_wr,
   output logic [fpol_pkg::USER_AW-1:0] nvm_addr,
   output logic [7:0]                  nvm_data
);
   localparam int SW          = $clog2(NUM_SECTORS);
   localparam int PROG_CYCLES = SEC_PROG_TIME_US * fpol_pkg::CLK_FREQ_MHZ;
   localparam int UB          = fpol_pkg::USER_BYTES;
   localparam int UAW         = fpol_pkg::USER_AW;

   typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_PROG, ST_WAIT} fpol_st_t;

   typedef struct packed {
      logic [1:0]             cs_s;
      logic [1:0]             sck_s;
      logic [1:0]             si_s;
      logic [1:0]             wp_s;
      logic                   sck_d;
      logic [7:0]             sh;
      logic [2:0]             bitcnt;
      logic [2:0]             bytecnt;
      logic [7:0]             opcode;
      logic [23:0]            addr;
      logic [7:0]             wsr;
      logic                   reading;
      logic                   armed;
      logic                   ovf;
      logic                   push;
      logic [7:0]             push_data;
      logic                   so;
      logic                   so_oe_n;
      logic [NUM_SECTORS-1:0] flags;
      logic                   lock;
      logic                   write_enable_latch;
      logic                   used;
      fpol_st_t               st;
      logic [UB-1:0][7:0]     pbuf;
      logic [UB-1:0]          mask;
      logic [UAW-1:0]         wptr;
      logic [UAW:0]           pidx;
      logic [19:0]            tmr;
      logic                   nvm_wr;
      logic [UAW-1:0]         nvm_addr;
      logic [7:0]             nvm_data;
      logic [7:0]             status;
   } fpol_state_t;

   fpol_state_t r;
   fpol_state_t r_nxt;
   logic        f_in_ready;
   logic        f_out_valid;
   logic [7:0]  f_out_data;
   logic        f_out_ready;

   // ----------------------------------------------------------------
   // Data FIFO between the link and the page buffer
   // ----------------------------------------------------------------
   // The buffer side stalls while a program runs; a push that finds the
   // FIFO full marks the frame as overrun so it is aborted at release.
   assign f_out_ready = r.st == ST_IDLE;

   fpol_fifo #(.W(8), .D(fpol_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (r.push),
      .in_data   (r.push_data),
      .in_ready  (f_in_ready),
      .out_valid (f_out_valid),
      .out_data  (f_out_data),
      .out_ready (f_out_ready)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic       cs_hi;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_rise;
   logic       busy;
   logic       hw_lock;
   logic [7:0] byte_in;

   always_comb begin
      r_nxt    = r;
      cs_hi    = r.cs_s[1];
      sck_rise = r.sck_s[1] && !r.sck_d;
      sck_fall = !r.sck_s[1] && r.sck_d;
      cs_rise  = cs_hi && !r.reading && 1'b0;
      busy     = r.st != ST_IDLE;
      hw_lock  = !r.wp_s[1] && r.lock;
      byte_in  = {r.sh[6:0], r.si_s[1]};
      // Synchronisers: stage 0 feeds only stage 1
      r_nxt.cs_s  = {r.cs_s[0], cs_n};
      r_nxt.sck_s = {r.sck_s[0], sck};
      r_nxt.si_s  = {r.si_s[0], si};
      r_nxt.wp_s  = {r.wp_s[0], wp_n};
      r_nxt.sck_d = r.sck_s[1];
      r_nxt.push  = 1'b0;
      r_nxt.nvm_wr = 1'b0;
      if (r.push && !f_in_ready) begin
         r_nxt.ovf = 1'b1;
      end

      if (cs_hi) begin
         // Frame over: act on what the frame carried, then clear the frame state and disarm
         if (r.bytecnt != '0) begin
            cs_rise = 1'b1;
         end
         r_nxt.bitcnt  = '0;
         r_nxt.bytecnt = '0;
         r_nxt.reading = 1'b0;
         r_nxt.so_oe_n = 1'b1;
         r_nxt.armed   = 1'b0;
         r_nxt.ovf     = 1'b0;
      end else begin
         if (sck_rise) begin
            r_nxt.sh     = byte_in;
            r_nxt.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
               if (r.bytecnt != fpol_pkg::BYTES_WITH_DATA) begin
                  r_nxt.bytecnt = r.bytecnt + 3'h1;
               end
               case (r.bytecnt)
                  fpol_pkg::BYTE_OPCODE: begin
                     r_nxt.opcode = byte_in;
                     // write enable must already be set; new frame replaces buffer
                     if (byte_in == fpol_pkg::OP_PROG_SECUR && r.write_enable_latch && !busy) begin
                        r_nxt.armed = 1'b1;
                        r_nxt.mask  = '0;
                     end
                  end
                  fpol_pkg::BYTE_ADDR_HI: begin
                     r_nxt.addr[23:16] = byte_in;
                     r_nxt.wsr         = byte_in;
                  end
                  fpol_pkg::BYTE_ADDR_MID: begin
                     r_nxt.addr[15:8] = byte_in;
                  end
                  fpol_pkg::BYTE_ADDR_LO: begin
                     r_nxt.addr[7:0] = byte_in;
                     r_nxt.wptr      = byte_in[UAW-1:0];
                     if (r.opcode == fpol_pkg::OP_READ_PROT) begin
                        r_nxt.reading = 1'b1;
                     end
                  end
                  default: begin
                     if (r.armed) begin
                        r_nxt.push      = 1'b1;
                        r_nxt.push_data = byte_in;
                     end
                  end
               endcase
            end
         end
         if (sck_fall && r.reading) begin
            // Whole bytes of FFh or 00h are just the flag held on every bit
            r_nxt.so      = r.flags[r.addr[SECTOR_LSB +: SW]];
            r_nxt.so_oe_n = 1'b0;
         end
      end

      // --------------------------------------------------------------
      // Commands acted on at chip-select release
      // --------------------------------------------------------------
      if (cs_rise && !busy) begin
         case (r.opcode)
            fpol_pkg::OP_WRITE_EN: begin
               if (r.bytecnt == 3'h1 && r.bitcnt == '0) begin
                  r_nxt.write_enable_latch = 1'b1;
               end
            end
            fpol_pkg::OP_WRITE_STAT: begin
               if (r.bytecnt >= 3'h2 && !hw_lock) begin
                  r_nxt.lock = r.wsr[fpol_pkg::ST_LOCK_POS];
                  if (!r.lock) begin
                     if (r.wsr[5:2] == fpol_pkg::GLOBAL_PROT) begin
                        r_nxt.flags = '1;
                     end else if (r.wsr[5:2] == fpol_pkg::GLOBAL_UNPROT) begin
                        r_nxt.flags = '0;
                     end
                  end
               end
            end
            fpol_pkg::OP_PROT_SECT, fpol_pkg::OP_UNPROT_SECT: begin
               if (r.bytecnt >= fpol_pkg::BYTES_ADDRESSED && !hw_lock) begin
                  if (r.write_enable_latch && !r.lock) begin
                     r_nxt.flags[r.addr[SECTOR_LSB +: SW]] =
                        r.opcode == fpol_pkg::OP_PROT_SECT;
                  end
                  r_nxt.write_enable_latch = 1'b0;
               end
            end
            fpol_pkg::OP_PROG_SECUR: begin
               if (r.armed) begin
                  if (r.bytecnt == fpol_pkg::BYTES_WITH_DATA && r.bitcnt == '0
                      && !r.used && !r.ovf && !(r.push && !f_in_ready)) begin
                     r_nxt.st = ST_DRAIN;
                  end else begin
                     r_nxt.write_enable_latch = 1'b0;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // --------------------------------------------------------------
      // Buffer fill and self-timed security write
      // --------------------------------------------------------------
      if (f_out_valid && f_out_ready) begin
         r_nxt.pbuf[r.wptr] = f_out_data;
         r_nxt.mask[r.wptr] = 1'b1;
         r_nxt.wptr         = r.wptr + 1'b1;
      end
      case (r.st)
         ST_IDLE: begin
         end
         ST_DRAIN: begin
            if (!f_out_valid && !r.push) begin
               r_nxt.st   = ST_PROG;
               r_nxt.pidx = '0;
               r_nxt.write_enable_latch  = 1'b0;
               r_nxt.used = 1'b1;
            end
         end
         ST_PROG: begin
            // Unsent locations are never written and keep their erased value
            if (r.mask[r.pidx[UAW-1:0]]) begin
               r_nxt.nvm_wr = 1'b1;
            end
            // Only the 64 user locations can be addressed here
            r_nxt.nvm_addr = r.pidx[UAW-1:0];
            r_nxt.nvm_data = r.pbuf[r.pidx[UAW-1:0]];
            r_nxt.pidx     = r.pidx + 1'b1;
            if (r.pidx == (UAW+1)'(UB-1)) begin
               r_nxt.st  = ST_WAIT;
               r_nxt.tmr = 20'(PROG_CYCLES - UB);
            end
         end
         ST_WAIT: begin
            r_nxt.tmr = r.tmr - 20'h1;
            if (r.tmr == '0) begin
               r_nxt.st = ST_IDLE;
            end
         end
         default: begin
            r_nxt.st = ST_IDLE;
         end
      endcase

      // Status byte follows the state it will be registered with; the WP bit takes the current synchronised pin
      r_nxt.status = '0;
      r_nxt.status[fpol_pkg::ST_LOCK_POS] = r_nxt.lock;
      r_nxt.status[fpol_pkg::ST_WP_POS]   = r.wp_s[1];
      r_nxt.status[fpol_pkg::ST_SWP_POS +: 2] = (&r_nxt.flags) ? fpol_pkg::SWP_ALL :
         ((|r_nxt.flags) ? fpol_pkg::SWP_SOME : fpol_pkg::SWP_NONE);
      r_nxt.status[fpol_pkg::ST_WEL_POS]  = r_nxt.write_enable_latch;
      r_nxt.status[fpol_pkg::ST_BUSY_POS] = r_nxt.st != ST_IDLE;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r         <= '0;
         r.cs_s    <= 2'h3;
         r.so_oe_n <= 1'b1;
         r.flags   <= {NUM_SECTORS{fpol_pkg::FLAG_RST}};
         r.lock    <= fpol_pkg::LOCK_RST;
         r.st      <= ST_IDLE;
         r.status  <= {6'h0, 2'h0} | (fpol_pkg::SWP_ALL << fpol_pkg::ST_SWP_POS);
      end else begin
         r <= r_nxt;
      end
   end

   assign so             = r.so;
   assign so_oe_n        = r.so_oe_n;
   assign status_byte    = r.status;
   assign sector_flags   = r.flags;
   assign user_area_used = r.used;
   assign nvm_wr         = r.nvm_wr;
   assign nvm_addr       = r.nvm_addr;
   assign nvm_data       = r.nvm_data;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_so_float_cs: assert property (@(posedge clk) disable iff (sys_rst)
      r.cs_s[1] |=> r.so_oe_n)
      else $error("serial out driven after chip select release");

   a_so_flag_val: assert property (@(posedge clk) disable iff (sys_rst)
      !r.so_oe_n |-> r.so == r.flags[r.addr[SECTOR_LSB +: SW]])
      else $error("flag read data does not match sector flag");

   a_hw_lock_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (!r.wp_s[1] && r.lock) |=> ($stable(r.flags) && r.lock))
      else $error("protection changed under hardware lock");

   a_sw_lock_flag: assert property (@(posedge clk) disable iff (sys_rst)
      r.lock |=> $stable(r.flags))
      else $error("sector flags changed while locked");

   a_abort_wel_clr: assert property (@(posedge clk) disable iff (sys_rst)
      (r.cs_s[1] && r.bytecnt != '0 && r.armed && r.st == ST_IDLE
       && (r.bitcnt != '0 || r.bytecnt != fpol_pkg::BYTES_WITH_DATA))
      |=> !r.write_enable_latch ##0 r.st == ST_IDLE)
      else $error("aborted security program left write enable set");

   a_prog_busy_wel: assert property (@(posedge clk) disable iff (sys_rst)
      r.st == ST_PROG |-> (status_byte[fpol_pkg::ST_BUSY_POS]
                           && !status_byte[fpol_pkg::ST_WEL_POS]))
      else $error("programming without busy or with write enable set");

   a_user_once: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(r.st == ST_DRAIN) |-> !$past(r.used))
      else $error("user area programmed twice");

   a_swp_summary: assert property (@(posedge clk) disable iff (sys_rst)
      status_byte[3:2] == ((&r.flags) ? 2'h3 : ((|r.flags) ? 2'h1 : 2'h0)))
      else $error("protection summary field wrong");

   c_flag_read:  cover property (@(posedge clk) disable iff (sys_rst)
      $fell(r.so_oe_n) && r.so);
   c_prog_start: cover property (@(posedge clk) disable iff (sys_rst)
      $rose(r.st == ST_PROG));
   c_lock_set:   cover property (@(posedge clk) disable iff (sys_rst)
      $rose(r.lock));
endmodule

//--- fpol_host_model.sv
// Serial link host model: drives chip select, serial clock and data in
`timescale 1ns/100ps

module fpol_host_model (
   // Clock
   input  wire logic clk,
   // Link pins
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so
);
   logic [7:0] rx;

   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b1;
      rx   = 8'h00;
   end

   // ----------------------------------------------------------------
   // One frame, mode 0, MSB first; sck stands low outside frames
   // ----------------------------------------------------------------
   // Bit counts that are not a multiple of 8 give a release off a byte boundary on purpose
   task automatic frame(input logic [63:0] d, input int nbits);
      repeat (4) @(negedge clk);
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         si = d[63-i];
         repeat (4) @(negedge clk);
         sck = 1'b1;
         repeat (4) @(negedge clk);
         rx  = {rx[6:0], so};
         sck = 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      // Released line must not keep showing the last bit
      si = ~si;
      repeat (8) @(negedge clk);
   endtask
endmodule

//--- fpol_protect_otp_bench.sv
// Self-checking bench for the protection and security-area block
`timescale 1ns/100ps

module fpol_protect_otp_bench;
   logic        clk;
   logic        sys_rst;
   logic        wp_n;
   logic        cs_n;
   logic        sck;
   logic        si;
   logic        so;
   logic        so_oe_n;
   logic [7:0]  status_byte;
   logic [3:0]  sector_flags;
   logic        user_area_used;
   logic        nvm_wr;
   logic [5:0]  nvm_addr;
   logic [7:0]  nvm_data;
   int          bad_count;
   int          samples_checked;
   logic [13:0] wr_log[$];

   // Short program time keeps the busy window near 100 cycles
   fpol_protect_otp #(.SEC_PROG_TIME_US(10)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
      .so_oe_n(so_oe_n), .wp_n(wp_n), .status_byte(status_byte),
      .sector_flags(sector_flags), .user_area_used(user_area_used),
      .nvm_wr(nvm_wr), .nvm_addr(nvm_addr), .nvm_data(nvm_data));

   fpol_host_model i_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      if (nvm_wr === 1'b1) wr_log.push_back({nvm_addr, nvm_data});
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic run(input logic [63:0] d, input int n);
      i_host.frame(d, n);
   endtask

   task automatic wen();
      run({8'h11, 56'h0}, 8);
   endtask

   task automatic wst(input logic [7:0] v);
      run({8'h12, v, 48'h0}, 16);
   endtask

   task automatic unprot(input logic [23:0] a);
      wen();
      run({8'h14, a, 32'h0}, 32);
   endtask

   task automatic rdf(input logic [23:0] a, input logic [7:0] exp);
      run({8'h3c, a, 32'h0}, 40);
      check(i_host.rx, exp);
      check(so_oe_n, 1'b1);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check(status_byte, 8'h1c);
      check(sector_flags, 4'hf);
      $display("test reset done");
   endtask

   task automatic t_flags();
      wp_n = 1'b0;
      rdf(24'h01_2345, 8'hff);
      wp_n = 1'b1;
      unprot(24'h01_0000);
      check(sector_flags, 4'hd);
      check(status_byte[3:1], 3'b010);
      rdf(24'h01_ffff, 8'h00);
      $display("test flags done");
   endtask

   task automatic t_lock();
      wst(8'h00);
      check(sector_flags, 4'h0);
      check(status_byte[3:2], 2'b00);
      wst(8'hbc);
      check({status_byte[7], sector_flags}, 5'h1f);
      unprot(24'h00_0000);
      check(sector_flags, 4'hf);
      wst(8'h00);
      check({status_byte[7], sector_flags}, 5'h0f);
      wst(8'hbc);
      wp_n = 1'b0;
      wst(8'h00);
      check(status_byte[7], 1'b1);
      unprot(24'h02_0000);
      check(sector_flags, 4'hf);
      wp_n = 1'b1;
      wst(8'h00);
      check({status_byte[7], sector_flags}, 5'h0f);
      $display("test lock done");
   endtask

   task automatic t_secur();
      wen();
      run({8'h9b, 24'h00_0000, 8'h55, 24'h0}, 36);
      check(status_byte[1], 1'b0);
      check(wr_log.size(), 0);
      wen();
      run({8'h9b, 24'hff_ff3e, 24'ha1b2c3, 8'h0}, 56);
      check(status_byte[1:0], 2'b01);
      for (int i = 0; i < 400 && status_byte[0] !== 1'b0; i++) @(negedge clk);
      check(status_byte[0], 1'b0);
      check(user_area_used, 1'b1);
      check(wr_log.size(), 3);
      // The write port walks locations in ascending order, so the wrapped byte comes first
      check(wr_log[0], {6'h00, 8'hc3});
      check(wr_log[1], {6'h3e, 8'ha1});
      check(wr_log[2], {6'h3f, 8'hb2});
      wr_log.delete();
      wen();
      run({8'h9b, 24'h00_0000, 8'h77, 24'h0}, 40);
      check(status_byte[1:0], 2'b00);
      check(wr_log.size(), 0);
      $display("test security done");
   endtask

   initial begin
      #2_000_000;
      bad_count++;
      end_of_test();
   end

   initial begin
      sys_rst         = 1'b1;
      wp_n            = 1'b1;
      bad_count       = 0;
      samples_checked = 0;
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_flags();
      t_lock();
      t_secur();
      end_of_test();
   end
endmodule
